// File: hw/brc_pkg.sv
// Purpose: shared constants for the buck rail configuration slice
// Assumes: byte wide registers behind the serial configuration engine
// Notes: voltages in mV, currents in mA, frequencies in kHz
package brc_pkg;
    // ***********************************
    // register offsets
    // ***********************************
    localparam logic [7:0] OFS_RAIL_ONE_CODE = 8'h1C;
    localparam logic [7:0] OFS_RAIL_TWO_CFG = 8'h1D;
    localparam logic [7:0] OFS_RAIL_TWO_CODE = 8'h1E;
    localparam logic [7:0] OFS_RAIL_THREE_CFG = 8'h1F;
    // ***********************************
    // field positions and write masks
    // ***********************************
    localparam int CUR_LSB = 6;
    localparam int SLEW_LSB = 4;
    localparam int RATE_LSB = 1;
    localparam int ONE_CODE_LSB = 2;
    localparam int TWO_CODE_LSB = 1;
    localparam logic [7:0] CFG_MASK = 8'hFE;
    localparam logic [7:0] ONE_CODE_MASK = 8'hFC;
    localparam logic [7:0] TWO_CODE_MASK = 8'hFE;
    localparam logic [7:0] RD_IDLE = 8'h00;
    // ***********************************
    // reset values
    // ***********************************
    localparam logic [7:0] CFG_RESET = 8'h6A;
    localparam logic [7:0] ONE_RESET_HIGH = 8'hA0;
    localparam logic [7:0] ONE_RESET_FLOAT = 8'hA0;
    localparam logic [7:0] ONE_RESET_LOW = 8'hF0;
    localparam logic [7:0] TWO_CODE_RESET = 8'h3C;
    // ***********************************
    // sensed select pin states
    // ***********************************
    typedef enum logic [1:0] {
        BRC_PIN_LOW = 2'h0,
        BRC_PIN_FLOAT = 2'h1,
        BRC_PIN_HIGH = 2'h2
    } brc_pin_t;
    // ***********************************
    // electrical decode constants
    // ***********************************
    localparam logic [11:0] ONE_BASE_MV = 12'h6A4;
    localparam logic [11:0] ONE_STEP_MV = 12'h014;
    localparam logic [5:0] ONE_CLAMP_CODE = 6'h3C;
    localparam logic [11:0] ONE_MAX_MV = 12'hB54;
    localparam logic [11:0] TWO_BASE_MV = 12'h384;
    localparam logic [11:0] TWO_STEP_MV = 12'h00A;
    localparam logic [6:0] TWO_CLAMP_CODE = 7'h6E;
    localparam logic [11:0] TWO_MAX_MV = 12'h7D0;
    localparam logic [12:0] TWO_CUR_BASE_MA = 13'h07D0;
    localparam logic [12:0] THREE_CUR_BASE_MA = 13'h0FA0;
    localparam logic [12:0] CUR_STEP_MA = 13'h03E8;
    localparam logic [4:0] SLEW_FAST_MVUS = 5'h14;
    localparam logic [4:0] SLEW_STEP_MVUS = 5'h05;
    localparam logic [4:0] SLEW_DOWN_MVUS = 5'h05;
    localparam logic [2:0] RATE_FIRST_CODE = 3'h4;
    localparam logic [11:0] RATE_FLOOR_KHZ = 12'h3E8;
    localparam logic [11:0] RATE_STEP_KHZ = 12'h1F4;
endpackage

// File: hw/brc_cfg_if.sv
// Purpose: carrier between the register slice and one rail config
// Assumes: single clock domain
// Notes: regs side writes, rail side holds and decodes
`timescale 1ns/1ps
interface brc_cfg_if;
    logic wrEn;
    logic [7:0] wrData;
    logic [7:0] cfg;
    logic [12:0] currentLimitMa;
    logic [4:0] slewUpMvPerUs;
    logic [4:0] slewDownMvPerUs;
    logic [11:0] switchRateKhz;
    modport regs (output wrEn, wrData, input cfg, currentLimitMa, slewUpMvPerUs,
        slewDownMvPerUs, switchRateKhz);
    modport rail (input wrEn, wrData, output cfg, currentLimitMa, slewUpMvPerUs,
        slewDownMvPerUs, switchRateKhz);
endinterface

// File: hw/brc_rail_cfg.sv
// Purpose: one rail configuration register with field decode
// Assumes: writes arrive as one-cycle strobes
// Notes: bit 0 is reserved, reads zero, ignores writes
`timescale 1ns/1ps
module brc_rail_cfg #(
    parameter logic [12:0] CUR_BASE_MA = brc_pkg::TWO_CUR_BASE_MA
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register carrier
    brc_cfg_if.rail bus
);
    import brc_pkg::*;

    // ***********************************
    // register storage
    // ***********************************
    // reserved bit masked on the way in
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus.cfg <= CFG_RESET;
        end else if (bus.wrEn) begin
            bus.cfg <= bus.wrData & CFG_MASK;
        end
    end

    // ***********************************
    // field decode
    // ***********************************
    // decoded from the next value so outputs track the register in the same cycle
    logic [7:0] next_cfg;
    assign next_cfg = bus.wrEn ? (bus.wrData & CFG_MASK) : bus.cfg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus.currentLimitMa <= CUR_BASE_MA + CUR_STEP_MA;
            bus.slewUpMvPerUs <= SLEW_STEP_MVUS + SLEW_STEP_MVUS;
            bus.slewDownMvPerUs <= SLEW_DOWN_MVUS;
            bus.switchRateKhz <= RATE_FLOOR_KHZ + RATE_STEP_KHZ + RATE_STEP_KHZ;
        end else begin
            // one amp per code above the rail base
            bus.currentLimitMa <= CUR_BASE_MA
                + CUR_STEP_MA * 13'(next_cfg[CUR_LSB +: 2]);
            bus.slewUpMvPerUs <= SLEW_FAST_MVUS
                - SLEW_STEP_MVUS * 5'(next_cfg[SLEW_LSB +: 2]);
            bus.slewDownMvPerUs <= SLEW_DOWN_MVUS;
            // low half of the code space all means the floor rate
            if (next_cfg[RATE_LSB +: 3] < RATE_FIRST_CODE) begin
                bus.switchRateKhz <= RATE_FLOOR_KHZ;
            end else begin
                bus.switchRateKhz <= RATE_FLOOR_KHZ + RATE_STEP_KHZ
                    * 12'(next_cfg[RATE_LSB +: 3] - RATE_FIRST_CODE + 3'h1);
            end
        end
    end
endmodule

// File: hw/buck_rail_config_regs.sv
// Purpose: configuration registers for rails one to three
// Assumes: serial engine gives byte address, write and read strobes
// Notes: select pin state is sensed elsewhere and arrives as a code
`timescale 1ns/1ps
module buck_rail_config_regs (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port from the serial engine
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // sensed select pin state
    input wire brc_pkg::brc_pin_t railOneSelectPin,
    // rail one settings
    output logic [5:0] railOneVoltageCode,
    output logic [11:0] railOneMillivolts,
    // rail two settings
    output logic [6:0] railTwoVoltageCode,
    output logic [11:0] railTwoMillivolts,
    output logic [12:0] railTwoCurrentLimitMa,
    output logic [4:0] railTwoSlewUpMvPerUs,
    output logic [4:0] railTwoSlewDownMvPerUs,
    output logic [11:0] railTwoSwitchRateKhz,
    // rail three settings
    output logic [12:0] railThreeCurrentLimitMa,
    output logic [4:0] railThreeSlewUpMvPerUs,
    output logic [4:0] railThreeSlewDownMvPerUs,
    output logic [11:0] railThreeSwitchRateKhz
);
    import brc_pkg::*;

    // ***********************************
    // helpers
    // ***********************************

    // copy index for a sensed pin state; an illegal code falls back to float
    function automatic logic [1:0] copyOf(input brc_pin_t pin);
        unique case (pin)
            BRC_PIN_HIGH: copyOf = 2'h0;
            BRC_PIN_FLOAT: copyOf = 2'h1;
            BRC_PIN_LOW: copyOf = 2'h2;
            default: copyOf = 2'h1;
        endcase
    endfunction

    // reset value of each rail one copy
    function automatic logic [7:0] copyReset(input int idx);
        unique case (idx)
            0: copyReset = ONE_RESET_HIGH;
            1: copyReset = ONE_RESET_FLOAT;
            default: copyReset = ONE_RESET_LOW;
        endcase
    endfunction

    // ***********************************
    // pin state capture
    // ***********************************
    logic [1:0] activeCopy;

    // registered so a pin change moves all rail one outputs together
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            activeCopy <= 2'h1;
        end else begin
            activeCopy <= copyOf(railOneSelectPin);
        end
    end

    // ***********************************
    // address decode
    // ***********************************
    logic hitOne;
    logic hitTwoCfg;
    logic hitTwoCode;
    logic hitThreeCfg;

    // one strobe per register, shared by reads and writes
    assign hitOne = (regAddr == OFS_RAIL_ONE_CODE);
    assign hitTwoCfg = (regAddr == OFS_RAIL_TWO_CFG);
    assign hitTwoCode = (regAddr == OFS_RAIL_TWO_CODE);
    assign hitThreeCfg = (regAddr == OFS_RAIL_THREE_CFG);

    // ***********************************
    // rail one code bank
    // ***********************************
    logic [7:0] railOneBank [3];
    logic [1:0] writeCopy;

    // host writes land in the copy the pin currently selects
    assign writeCopy = copyOf(railOneSelectPin);

    generate
        for (genvar i = 0; i < 3; i++) begin : g_bank
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    railOneBank[i] <= copyReset(i);
                end else if (regWrEn && hitOne && writeCopy == 2'(i)) begin
                    railOneBank[i] <= regWrData & ONE_CODE_MASK;
                end
            end
        end
    endgenerate

    // ***********************************
    // rail two code register
    // ***********************************
    logic [7:0] railTwoCode;

    // single copy; the select pin plays no part here
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            railTwoCode <= TWO_CODE_RESET;
        end else if (regWrEn && hitTwoCode) begin
            railTwoCode <= regWrData & TWO_CODE_MASK;
        end
    end

    // ***********************************
    // rail two and three config registers
    // ***********************************
    brc_cfg_if twoBus ();
    brc_cfg_if threeBus ();

    assign twoBus.wrEn = regWrEn && hitTwoCfg;
    assign twoBus.wrData = regWrData;
    assign threeBus.wrEn = regWrEn && hitThreeCfg;
    assign threeBus.wrData = regWrData;

    brc_rail_cfg #(
        .CUR_BASE_MA(TWO_CUR_BASE_MA)
    ) u_two (
        .clock(clock),
        .rst_n(rst_n),
        .bus(twoBus)
    );

    brc_rail_cfg #(
        .CUR_BASE_MA(THREE_CUR_BASE_MA)
    ) u_three (
        .clock(clock),
        .rst_n(rst_n),
        .bus(threeBus)
    );

    assign railTwoCurrentLimitMa = twoBus.currentLimitMa;
    assign railTwoSlewUpMvPerUs = twoBus.slewUpMvPerUs;
    assign railTwoSlewDownMvPerUs = twoBus.slewDownMvPerUs;
    assign railTwoSwitchRateKhz = twoBus.switchRateKhz;
    assign railThreeCurrentLimitMa = threeBus.currentLimitMa;
    assign railThreeSlewUpMvPerUs = threeBus.slewUpMvPerUs;
    assign railThreeSlewDownMvPerUs = threeBus.slewDownMvPerUs;
    assign railThreeSwitchRateKhz = threeBus.switchRateKhz;

    // ***********************************
    // applied rail one setting
    // ***********************************
    logic [5:0] oneCode;

    assign oneCode = railOneBank[activeCopy][7:ONE_CODE_LSB];

    // code and voltage come from the copy the pin selects
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            railOneVoltageCode <= 6'h00;
            railOneMillivolts <= ONE_BASE_MV;
        end else begin
            railOneVoltageCode <= oneCode;
            // codes past the clamp still mean the top voltage
            if (oneCode >= ONE_CLAMP_CODE) begin
                railOneMillivolts <= ONE_MAX_MV;
            end else begin
                railOneMillivolts <= ONE_BASE_MV + ONE_STEP_MV * 12'(oneCode);
            end
        end
    end

    // ***********************************
    // applied rail two voltage
    // ***********************************
    logic [6:0] twoCode;

    assign twoCode = railTwoCode[7:TWO_CODE_LSB];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            railTwoVoltageCode <= 7'h00;
            railTwoMillivolts <= TWO_BASE_MV;
        end else begin
            railTwoVoltageCode <= twoCode;
            if (twoCode >= TWO_CLAMP_CODE) begin
                railTwoMillivolts <= TWO_MAX_MV;
            end else begin
                railTwoMillivolts <= TWO_BASE_MV + TWO_STEP_MV * 12'(twoCode);
            end
        end
    end

    // ***********************************
    // read path
    // ***********************************
    logic [7:0] next_regRdData;

    // rail one read shows the copy the pin selects right now
    always_comb begin
        next_regRdData = RD_IDLE;
        if (hitOne) begin
            next_regRdData = railOneBank[copyOf(railOneSelectPin)];
        end else if (hitTwoCfg) begin
            next_regRdData = twoBus.cfg;
        end else if (hitTwoCode) begin
            next_regRdData = railTwoCode;
        end else if (hitThreeCfg) begin
            next_regRdData = threeBus.cfg;
        end
    end

    // one cycle latency; unmapped addresses answer zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= RD_IDLE;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                regRdData <= next_regRdData;
            end
        end
    end
endmodule

// File: testbench/brc_checker.sv
// Purpose: port assertions for the rail config registers
// Assumes: one clock, asynchronous active low reset
// Notes: decode checks wait until a written value has settled
`timescale 1ns/1ps
module brc_checker (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    // settings
    input wire logic [5:0] railOneVoltageCode,
    input wire logic [11:0] railOneMillivolts,
    input wire logic [6:0] railTwoVoltageCode,
    input wire logic [11:0] railTwoMillivolts,
    input wire logic [12:0] railTwoCurrentLimitMa,
    input wire logic [4:0] railTwoSlewUpMvPerUs,
    input wire logic [4:0] railTwoSlewDownMvPerUs,
    input wire logic [11:0] railTwoSwitchRateKhz,
    input wire logic [12:0] railThreeCurrentLimitMa,
    input wire logic [4:0] railThreeSlewUpMvPerUs,
    input wire logic [4:0] railThreeSlewDownMvPerUs,
    input wire logic [11:0] railThreeSwitchRateKhz
);
    // ********
    // checks
    // ********
    logic wrTwo;
    logic wrCode;
    logic wrThree;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // write strobe per register, except the rail one code register
    assign wrTwo = regWrEn && regAddr == 8'h1D;
    assign wrCode = regWrEn && regAddr == 8'h1E;
    assign wrThree = regWrEn && regAddr == 8'h1F;
    // low codes share the floor rate
    function automatic int rateKhz(input logic [7:0] cfg);
        return cfg[3:1] < 3'h4 ? 1000 : 500 * cfg[3:1] - 500;
    endfunction
    read_reserved_zero_a: assert property (regRdEn |=> regRdValid && !regRdData[0])
        else $error("read answer late or reserved bit set");
    one_voltage_a: assert property ($stable(railOneVoltageCode) |-> railOneMillivolts ==
        (railOneVoltageCode >= 6'h3C ? 2900 : 1700 + 20 * railOneVoltageCode))
        else $error("rail one millivolts wrong");
    two_voltage_a: assert property ($stable(railTwoVoltageCode) |-> railTwoMillivolts ==
        (railTwoVoltageCode >= 7'h6E ? 2000 : 900 + 10 * railTwoVoltageCode))
        else $error("rail two millivolts wrong");
    two_limit_a: assert property (wrTwo ##1 !wrTwo |=>
        railTwoCurrentLimitMa == 2000 + 1000 * ($past(regWrData, 2) >> 6))
        else $error("rail two limit wrong");
    three_limit_a: assert property (wrThree ##1 !wrThree |=>
        railThreeCurrentLimitMa == 4000 + 1000 * ($past(regWrData, 2) >> 6))
        else $error("rail three limit wrong");
    two_slew_up_a: assert property (wrTwo ##1 !wrTwo |=>
        railTwoSlewUpMvPerUs == 20 - 5 * (($past(regWrData, 2) >> 4) & 3))
        else $error("rail two upward slew wrong");
    three_slew_up_a: assert property (wrThree ##1 !wrThree |=>
        railThreeSlewUpMvPerUs == 20 - 5 * (($past(regWrData, 2) >> 4) & 3))
        else $error("rail three upward slew wrong");
    two_rate_a: assert property (wrTwo ##1 !wrTwo |=>
        railTwoSwitchRateKhz == rateKhz($past(regWrData, 2)))
        else $error("rail two rate wrong");
    slew_down_fixed_a: assert property (railTwoSlewDownMvPerUs == 5 &&
        railThreeSlewDownMvPerUs == 5) else $error("downward slew not fixed");
    three_rate_a: assert property (wrThree ##1 !wrThree |=>
        railThreeSwitchRateKhz == rateKhz($past(regWrData, 2)))
        else $error("rail three rate wrong");
    two_code_a: assert property (wrCode ##1 !wrCode |=>
        railTwoVoltageCode == ($past(regWrData, 2) >> 1)) else $error("rail two code wrong");
endmodule
bind buck_rail_config_regs brc_checker brc_checker_i (.*);

// File: testbench/brc_host_model.sv
// Purpose: host side of the byte register port
// Assumes: one strobe per access, answer one cycle later
// Notes: released lines carry the inverse of the last value
`timescale 1ns/1ps
module brc_host_model (
    // clock
    input wire logic clock,
    // register port
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrEn,
    output logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid
);
    // ********
    // accesses
    // ********
    // idle levels from time zero
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clock);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask
    // a missing answer comes back unknown so any compare fails
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clock);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        #1;
        d = (regRdValid === 1'b1) ? regRdData : 8'hXX;
    endtask
endmodule

// File: testbench/tb_top.sv
// Purpose: self-checking bench for the rail config registers
// Assumes: host model speaks the byte register port
// Notes: expectations come from field codes, not from outputs
`timescale 1ns/1ps
module tb_top;
    import brc_pkg::*;
    // ********
    // bench
    // ********
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    brc_pin_t railOneSelectPin = BRC_PIN_HIGH;
    logic [7:0] regAddr, regWrData, regRdData, d;
    logic regWrEn, regRdEn, regRdValid;
    logic [5:0] railOneVoltageCode;
    logic [6:0] railTwoVoltageCode;
    logic [11:0] railOneMillivolts, railTwoMillivolts;
    logic [11:0] railTwoSwitchRateKhz, railThreeSwitchRateKhz;
    logic [12:0] railTwoCurrentLimitMa, railThreeCurrentLimitMa;
    logic [4:0] railTwoSlewUpMvPerUs, railTwoSlewDownMvPerUs;
    logic [4:0] railThreeSlewUpMvPerUs, railThreeSlewDownMvPerUs;
    int num_errors = 0;
    int checks = 0;
    int rateTab [8] = '{1000, 1000, 1000, 1000, 1500, 2000, 2500, 3000};
    always #2 clock = ~clock;
    buck_rail_config_regs buck_rail_config_regs_i (.*);
    brc_host_model brc_host_model_i (.*);
    task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got);
        checks++;
        if (got !== expv) begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, expv, got);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] expv, input string what);
        logic [7:0] got;
        brc_host_model_i.rd(a, got);
        chk(what, expv, got);
    endtask
    task automatic rst();
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1;
    endtask
    // pin change needs two cycles to reach the applied code
    task automatic pin(input brc_pin_t p);
        @(posedge clock);
        railOneSelectPin <= p;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic outs(input int l2, l3, u2, u3, r2, r3);
        chk("limit two", l2, railTwoCurrentLimitMa);
        chk("limit three", l3, railThreeCurrentLimitMa);
        chk("slew up two", u2, railTwoSlewUpMvPerUs);
        chk("slew up three", u3, railThreeSlewUpMvPerUs);
        chk("slew down two", 5, railTwoSlewDownMvPerUs);
        chk("slew down three", 5, railThreeSlewDownMvPerUs);
        chk("rate two", r2, railTwoSwitchRateKhz);
        chk("rate three", r3, railThreeSwitchRateKhz);
    endtask
    task automatic one(input brc_pin_t p, input logic [7:0] w, input int code, mv);
        pin(p);
        brc_host_model_i.wr(8'h1C, w);
        rc(8'h1C, w & 8'hFC, "one copy");
        chk("one code", code, railOneVoltageCode);
        chk("one mv", mv, railOneMillivolts);
    endtask
    task automatic two(input logic [7:0] w, input int code, mv);
        brc_host_model_i.wr(8'h1E, w);
        rc(8'h1E, w & 8'hFE, "two code reg");
        chk("two code", code, railTwoVoltageCode);
        chk("two mv", mv, railTwoMillivolts);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge clock);
        num_errors++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        rst();
        rc(8'h1D, 8'h6A, "cfg two reset");
        rc(8'h1F, 8'h6A, "cfg three reset");
        rc(8'h1E, 8'h3C, "two code reset");
        rc(8'h1C, 8'hA0, "one high reset");
        chk("one mv reset", 2500, railOneMillivolts);
        chk("two mv reset", 1200, railTwoMillivolts);
        outs(3000, 5000, 10, 10, 2000, 2000);
        for (int i = 0; i < 8; i++) begin
            d = {i[1:0], i[1:0], i[2:0], 1'b1};
            brc_host_model_i.wr(8'h1D, d);
            brc_host_model_i.wr(8'h1F, d ^ 8'hFE);
            rc(8'h1D, d & 8'hFE, "cfg two");
            rc(8'h1F, (d ^ 8'hFE) & 8'hFE, "cfg three");
            outs(2000 + 1000 * i[1:0], 7000 - 1000 * i[1:0], 20 - 5 * i[1:0],
                5 + 5 * i[1:0], rateTab[i], rateTab[7 - i]);
        end
        one(BRC_PIN_FLOAT, 8'hEF, 59, 2880);
        one(BRC_PIN_HIGH, 8'h04, 1, 1720);
        one(BRC_PIN_LOW, 8'hF3, 60, 2900);
        one(BRC_PIN_LOW, 8'hFF, 63, 2900);
        pin(BRC_PIN_FLOAT);
        rc(8'h1C, 8'hEC, "float copy kept");
        chk("float code", 59, railOneVoltageCode);
        pin(BRC_PIN_HIGH);
        rc(8'h1C, 8'h04, "high copy kept");
        two(8'hDC, 110, 2000);
        two(8'hDB, 109, 1990);
        two(8'hFF, 127, 2000);
        two(8'h01, 0, 900);
        brc_host_model_i.wr(8'h20, 8'h55);
        rc(8'h20, 8'h00, "unmapped");
        rc(8'h1E, 8'h00, "two code kept");
        pin(BRC_PIN_LOW);
        rst();
        rc(8'h1C, 8'hF0, "one low reset");
        chk("one mv low", 2900, railOneMillivolts);
        rc(8'h1D, 8'h6A, "cfg two again");
        pin(BRC_PIN_FLOAT);
        rc(8'h1C, 8'hA0, "one float reset");
        tally_and_finish();
    end
endmodule
